// ---- capture_unit_map.svh ----
// Purpose: offsets, field positions, reset values and codes of the capture unit
// Assumes: included by bare name
// Notes: definitions only
`ifndef CAPTURE_UNIT_MAP_SVH
`define CAPTURE_UNIT_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_CAPTURE_CONTROL  4'h0
`define ADDR_HOLD_LOW         4'h1
`define ADDR_HOLD_HIGH        4'h2
`define ADDR_TIMER_LOW        4'h3
`define ADDR_TIMER_HIGH       4'h4
`define ADDR_TIMER_CONTROL    4'h5
`define ADDR_IRQ_STATUS       4'h6
`define ADDR_IRQ_CLEAR        4'h7
`define ADDR_IRQ_ENABLE       4'h8

// ****************************************
// fields and codes
// ****************************************
`define MODE_OFF              4'h0
`define MODE_FALL             4'h4
`define MODE_RISE             4'h5
`define MODE_RISE4            4'h6
`define MODE_RISE16           4'h7
`define MODE_CMP_HIGH         4'h8
`define MODE_CMP_LOW          4'h9
`define MODE_CMP_FLAG         4'hA
`define MODE_TRIGGER          4'hB
`define TCTRL_RUN_BIT         0
`define TCTRL_CONV_EN_BIT     1
`define IRQ_OVF_BIT           0
`define IRQ_CAPTURE_BIT       2
`define IRQ_WIDTH             3
`define PRESC_WRAP4           4'h3
`define PRESC_WRAP16          4'hF
`define RESET_BYTE            8'h00
`define RESET_WORD            16'h0000
`define TIMER_MAX             16'hFFFF

`endif

// ---- capture_unit_pkg.sv ----
// Purpose: shared types of the capture unit
// Assumes: nothing
// Notes: numbers live in capture_unit_map.svh
package capture_unit_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [3:0]  addr_t;
  typedef logic [3:0]  mode_t;
endpackage : capture_unit_pkg

// ---- edge_event_if.sv ----
// Purpose: carries synchronised pin edges between the capture modules
// Assumes: single clock
// Notes: pulses are one cycle wide
`timescale 1ns/100ps
`default_nettype none
interface edge_event_if;
  logic rise;
  logic fall;
  modport source (output rise, output fall);
  modport sink   (input  rise, input  fall);
endinterface : edge_event_if
`default_nettype wire

// ---- pin_edge_sync.sv ----
// Purpose: three-stage pin synchroniser and edge detector
// Assumes: pin is asynchronous to clock_i
// Notes: first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
  input  wire logic    clock_i,
  input  wire logic    nrst_i,
  input  wire logic    pin_i,
  edge_event_if.source edges
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       level_reg;
  logic       level_next;

  // ****************************************
  // synchroniser and edge detect
  // ****************************************
  always_comb begin
    sync_next  = {sync_reg[1:0], pin_i};
    level_next = level_reg;
    // a change counts once stages two and three agree [RULE17]
    if (sync_reg[1] == sync_reg[2]) begin
      level_next = sync_reg[2];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

  assign edges.rise = level_next & ~level_reg; // [RULE17]
  assign edges.fall = ~level_next & level_reg; // [RULE17]
endmodule : pin_edge_sync
`default_nettype wire

// ---- edge_prescaler.sv ----
// Purpose: selects the capture event from pin edges
// Assumes: mode comes from the control register
// Notes: counter held clear when off or not capturing
`timescale 1ns/100ps
`default_nettype none
`include "capture_unit_map.svh"
module edge_prescaler
  import capture_unit_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  input  wire capture_unit_pkg::mode_t mode_i,
  edge_event_if.sink                  edges,
  output logic                        capture_o
);
  logic [3:0] count_reg;
  logic [3:0] count_next;

  always_comb begin
    count_next = count_reg;
    capture_o  = 1'b0;
    case (mode_i)
      `MODE_FALL: begin
        capture_o = edges.fall; // [RULE2]
      end
      `MODE_RISE: begin
        capture_o = edges.rise; // [RULE2]
      end
      `MODE_RISE4: begin
        // count kept across a direct change of setting [RULE10]
        if (edges.rise) begin
          count_next = (count_reg >= `PRESC_WRAP4) ? 4'h0 : count_reg + 4'h1; // [RULE18]
          capture_o  = (count_reg >= `PRESC_WRAP4); // [RULE2] [RULE18]
        end
      end
      `MODE_RISE16: begin
        if (edges.rise) begin
          count_next = count_reg + 4'h1; // [RULE18]
          capture_o  = (count_reg == `PRESC_WRAP16); // [RULE2]
        end
      end
      default: begin
        count_next = 4'h0; // off or not capture [RULE9]
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= 4'h0; // [RULE9]
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : edge_prescaler
`default_nettype wire

// ---- timer_capture_event_trigger.sv ----
// Purpose: capture / compare / special event trigger unit with its 16-bit timer
// Assumes: register port with read data one cycle after the read strobe
// Notes: pin level is sampled even while the pin is driven as output
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "capture_unit_map.svh"

// Function
// RULE1 - a capture event copies the full 16-bit timer count into the hold pair
// RULE2 - events: each falling, each rising, every 4th or 16th rising edge by mode
// RULE3 - each capture sets the capture flag; only software clears it
// RULE4 - a newer capture overwrites an unread value with no overrun sign
// RULE5 - edges are seen from the pin level even when the pin is an output
// RULE6 - software keeps the pin an input during capture
// RULE7 - software runs the timer synchronously before using capture or trigger
// RULE8 - a mode change may raise a spurious capture flag
// RULE9 - prescaler counter cleared when off, not capturing, or on reset
// RULE10 - a direct prescaler change keeps the counter and may raise the flag
// RULE11 - software writes zero first, then the new mode, to change prescaler
// RULE12 - trigger mode on match resets the timer and requests converter start
// RULE13 - a trigger reset does not set the overflow flag
// RULE14 - a timer write in the trigger cycle wins over the reset
// RULE15 - in trigger mode the hold pair acts as the timer period
// RULE16 - compare modes match hold pair against timer and set the flag
// RULE17 - pin synchronised before edge detection, one pulse per edge
// RULE18 - 4 and 16 edge prescaler counts rising edges, capture on wrap
module timer_capture_event_trigger
  import capture_unit_pkg::*;
(
  input  wire logic                    clock_i,
  input  wire logic                    nrst_i,
  input  wire capture_unit_pkg::addr_t addr_i,
  input  wire capture_unit_pkg::byte_t wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic [7:0]                   rdata_o,
  input  wire logic                    capture_pin_i,
  output logic                         compare_pin_o,
  output logic                         compare_pin_oe_n_o,
  output logic                         convert_start_o,
  output logic                         irq_o
);
  import capture_unit_pkg::*;

  // ****************************************
  // state
  // ****************************************
  mode_t                 mode_reg;
  mode_t                 mode_next;
  word_t                 hold_reg;
  word_t                 hold_next;
  word_t                 timer_reg;
  word_t                 timer_next;
  byte_t                 tctrl_reg;
  byte_t                 tctrl_next;
  logic [`IRQ_WIDTH-1:0] status_reg;
  logic [`IRQ_WIDTH-1:0] status_next;
  logic [`IRQ_WIDTH-1:0] enable_reg;
  logic [`IRQ_WIDTH-1:0] enable_next;
  byte_t                 rdata_reg;
  byte_t                 rdata_next;
  logic                  pin_reg;
  logic                  pin_next;
  logic                  oe_n_reg;
  logic                  oe_n_next;
  logic                  conv_reg;
  logic                  conv_next;
  logic                  irq_reg;
  logic                  irq_next;
  logic                  capture_evt;
  logic                  match;
  logic                  compare_mode;
  logic                  trigger;
  logic                  timer_wr;
  logic                  overflow;
  logic [`IRQ_WIDTH-1:0] set_evt;

  edge_event_if edges ();

  // ****************************************
  // pin edges and prescaler
  // ****************************************
  // pin read directly, whether driven by the port or not [RULE5]
  pin_edge_sync u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .pin_i   (capture_pin_i),
    .edges   (edges)
  );

  edge_prescaler u_presc (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .mode_i    (mode_reg),
    .edges     (edges),
    .capture_o (capture_evt)
  );

  // ****************************************
  // timer, compare and trigger
  // ****************************************
  always_comb begin
    compare_mode = mode_reg[3];
    match        = compare_mode && (hold_reg == timer_reg); // [RULE16]
    trigger      = match && (mode_reg == `MODE_TRIGGER); // [RULE12] [RULE15]
    timer_wr     = wr_i && ((addr_i == `ADDR_TIMER_LOW) || (addr_i == `ADDR_TIMER_HIGH));
    overflow     = 1'b0;
    timer_next   = timer_reg;
    if (timer_wr) begin
      // software write beats the trigger reset [RULE14]
      if (addr_i == `ADDR_TIMER_LOW) begin
        timer_next = {timer_reg[15:8], wdata_i};
      end else begin
        timer_next = {wdata_i, timer_reg[7:0]};
      end
    end else if (trigger) begin
      timer_next = `RESET_WORD; // no overflow flag here [RULE12] [RULE13]
    end else if (tctrl_reg[`TCTRL_RUN_BIT]) begin
      timer_next = timer_reg + 16'h0001;
      overflow   = (timer_reg == `TIMER_MAX);
    end
    // capture only in capture modes; new value overwrites old [RULE1] [RULE4]
    hold_next = hold_reg;
    if (capture_evt) begin
      hold_next = timer_reg; // [RULE1] [RULE4]
    end else if (wr_i && (addr_i == `ADDR_HOLD_LOW)) begin
      hold_next = {hold_reg[15:8], wdata_i};
    end else if (wr_i && (addr_i == `ADDR_HOLD_HIGH)) begin
      hold_next = {wdata_i, hold_reg[7:0]};
    end
    // compare pin action
    pin_next  = pin_reg;
    oe_n_next = ~(compare_mode && (mode_reg != `MODE_CMP_FLAG) && (mode_reg != `MODE_TRIGGER));
    if (match && (mode_reg == `MODE_CMP_HIGH)) begin
      pin_next = 1'b1;
    end else if (match && (mode_reg == `MODE_CMP_LOW)) begin
      pin_next = 1'b0;
    end
    conv_next = trigger && tctrl_reg[`TCTRL_CONV_EN_BIT]; // [RULE12]
  end

  // ****************************************
  // registers and interrupts
  // ****************************************
  always_comb begin
    mode_next   = mode_reg;
    tctrl_next  = tctrl_reg;
    enable_next = enable_reg;
    // a mode change is not masked; it may look like a capture [RULE8] [RULE10]
    if (wr_i && (addr_i == `ADDR_CAPTURE_CONTROL)) begin
      mode_next = wdata_i[3:0];
    end
    if (wr_i && (addr_i == `ADDR_TIMER_CONTROL)) begin
      tctrl_next = wdata_i;
    end
    if (wr_i && (addr_i == `ADDR_IRQ_ENABLE)) begin
      enable_next = wdata_i[`IRQ_WIDTH-1:0];
    end
    set_evt                   = '0;
    set_evt[`IRQ_OVF_BIT]     = overflow;
    set_evt[`IRQ_CAPTURE_BIT] = capture_evt | match; // [RULE3] [RULE16]
    status_next = status_reg;
    // clear first so a same-cycle event still sets [RULE3]
    if (wr_i && (addr_i == `ADDR_IRQ_CLEAR)) begin
      status_next = status_next & ~wdata_i[`IRQ_WIDTH-1:0];
    end
    status_next = status_next | set_evt;
    irq_next    = |(status_next & enable_next);
    rdata_next  = `RESET_BYTE;
    if (rd_i) begin
      case (addr_i)
        `ADDR_CAPTURE_CONTROL: rdata_next = {4'h0, mode_reg};
        `ADDR_HOLD_LOW:        rdata_next = hold_reg[7:0];
        `ADDR_HOLD_HIGH:       rdata_next = hold_reg[15:8];
        `ADDR_TIMER_LOW:       rdata_next = timer_reg[7:0];
        `ADDR_TIMER_HIGH:      rdata_next = timer_reg[15:8];
        `ADDR_TIMER_CONTROL:   rdata_next = tctrl_reg;
        `ADDR_IRQ_STATUS:      rdata_next = {5'h00, status_reg};
        `ADDR_IRQ_ENABLE:      rdata_next = {5'h00, enable_reg};
        default:               rdata_next = `RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg   <= `MODE_OFF;
      hold_reg   <= `RESET_WORD;
      timer_reg  <= `RESET_WORD;
      tctrl_reg  <= `RESET_BYTE;
      status_reg <= '0;
      enable_reg <= '0;
      rdata_reg  <= `RESET_BYTE;
      pin_reg    <= 1'b0;
      oe_n_reg   <= 1'b1;
      conv_reg   <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      hold_reg   <= hold_next;
      timer_reg  <= timer_next;
      tctrl_reg  <= tctrl_next;
      status_reg <= status_next;
      enable_reg <= enable_next;
      rdata_reg  <= rdata_next;
      pin_reg    <= pin_next;
      oe_n_reg   <= oe_n_next;
      conv_reg   <= conv_next;
      irq_reg    <= irq_next;
    end
  end

  assign rdata_o            = rdata_reg;
  assign compare_pin_o      = pin_reg;
  assign compare_pin_oe_n_o = oe_n_reg;
  assign convert_start_o    = conv_reg;
  assign irq_o              = irq_reg;
endmodule : timer_capture_event_trigger
`default_nettype wire

// ---- capture_unit_properties.sv ----
// Purpose: port-level assertions of the capture unit
// Assumes: bound onto timer_capture_event_trigger
// Notes: mode is internal, so checks key off control writes
`timescale 1ns/100ps
`default_nettype none
`include "capture_unit_map.svh"
module capture_unit_properties
  import capture_unit_pkg::*;
(
  input wire logic                    clock_i,
  input wire logic                    nrst_i,
  input wire capture_unit_pkg::addr_t addr_i,
  input wire capture_unit_pkg::byte_t wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [7:0]              rdata_o,
  input wire logic                    capture_pin_i,
  input wire logic                    compare_pin_o,
  input wire logic                    compare_pin_oe_n_o,
  input wire logic                    convert_start_o,
  input wire logic                    irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************
  // assertions
  // ****************************************
  a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read slot");
  a_wo_reads_zero: assert property (rd_i && (addr_i == `ADDR_IRQ_CLEAR || addr_i > `ADDR_IRQ_ENABLE)
    |=> rdata_o == 8'h00) else $error("write-only or unmapped read not zero");
  a_irq_sw_clear: assert property ($fell(irq_o) |-> $past(wr_i) &&
    ($past(addr_i) == `ADDR_IRQ_CLEAR || $past(addr_i) == `ADDR_IRQ_ENABLE)) else $error("irq dropped by itself");
  a_irq_masked: assert property (wr_i && addr_i == `ADDR_IRQ_ENABLE && wdata_i == 8'h00 |=> !irq_o)
    else $error("irq high with enables clear");
  a_conv_needs_en: assert property (wr_i && addr_i == `ADDR_TIMER_CONTROL && !wdata_i[`TCTRL_CONV_EN_BIT]
    ##1 !(wr_i && addr_i == `ADDR_TIMER_CONTROL) |=> !convert_start_o) else $error("convert start while disabled");
  a_oe_fall_cause: assert property ($fell(compare_pin_oe_n_o) |->
    ($past(wr_i) && $past(addr_i) == `ADDR_CAPTURE_CONTROL) || ($past(wr_i, 2) && $past(addr_i, 2) == 4'h0))
    else $error("pin driven without a mode write");
  a_oe_off_release: assert property (wr_i && addr_i == `ADDR_CAPTURE_CONTROL && wdata_i[3:0] == `MODE_OFF
    ##1 !(wr_i && addr_i == `ADDR_CAPTURE_CONTROL) |=> compare_pin_oe_n_o) else $error("pin driven while off");
  a_oe_cmp_drive: assert property (wr_i && addr_i == 4'h0 && wdata_i[3:0] == `MODE_CMP_HIGH
    ##1 !(wr_i && addr_i == 4'h0) |=> !compare_pin_oe_n_o) else $error("pin not driven in compare mode");
  c_irq_up: cover property ($rose(irq_o));
  c_conv: cover property (convert_start_o);
  c_drive: cover property (!compare_pin_oe_n_o && compare_pin_o);
endmodule : capture_unit_properties
bind timer_capture_event_trigger capture_unit_properties chk_u (.clock_i(clock_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_pin_i(capture_pin_i),
  .compare_pin_o(compare_pin_o), .compare_pin_oe_n_o(compare_pin_oe_n_o), .convert_start_o(convert_start_o),
  .irq_o(irq_o));
`default_nettype wire

// ---- capture_pin_source.sv ----
// Purpose: external signal source on the capture pin
// Assumes: pin is asynchronous, so it moves on the falling clock edge
// Notes: each pulse is one rising and one falling edge
`timescale 1ns/100ps
`default_nettype none
module capture_pin_source (
  input  wire logic clock_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // long levels so the synchroniser filter never drops an edge
  task automatic pulse();
    @(negedge clock_i) pin_o = 1'b1;
    repeat (8) @(negedge clock_i);
    pin_o = 1'b0;
    repeat (8) @(negedge clock_i);
  endtask : pulse
endmodule : capture_pin_source
`default_nettype wire

// ---- timer_capture_event_trigger_test.sv ----
// Purpose: register-level test of the capture unit
// Assumes: timer stopped while capturing, so held value is exact
// Notes: verdict printed by tally_and_finish
`timescale 1ns/100ps
`default_nettype none
`include "capture_unit_map.svh"
module timer_capture_event_trigger_test;
  import capture_unit_pkg::*;
  logic       clock_i = 1'b0;
  logic       nrst_i = 1'b0;
  addr_t      addr_i = 4'h0;
  byte_t      wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       capture_pin_i, compare_pin_o, compare_pin_oe_n_o, convert_start_o, irq_o;
  int         bad_count = 0;
  int         checks_done = 0;
  int         n;
  mode_t      modes [4] = '{`MODE_FALL, `MODE_RISE, `MODE_RISE4, `MODE_RISE16};
  int         needs [4] = '{1, 1, 4, 16};
  always #25 clock_i = ~clock_i;
  capture_pin_source pin_u (.clock_i(clock_i), .pin_o(capture_pin_i));
  timer_capture_event_trigger dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_pin_i(capture_pin_i), .compare_pin_o(compare_pin_o),
    .compare_pin_oe_n_o(compare_pin_oe_n_o), .convert_start_o(convert_start_o), .irq_o(irq_o));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk8(string what, byte_t exp, byte_t got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk1
  task automatic wr(addr_t a, byte_t d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(addr_t a, byte_t exp, string what);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk8(what, exp, rdata_o);
  endtask : rd
  task automatic set_timer(word_t v);
    wr(`ADDR_TIMER_LOW, v[7:0]);
    wr(`ADDR_TIMER_HIGH, v[15:8]);
  endtask : set_timer
  task automatic rd_hold(word_t v);
    rd(`ADDR_HOLD_LOW, v[7:0], "hold low");
    rd(`ADDR_HOLD_HIGH, v[15:8], "hold high");
  endtask : rd_hold
  // sampled just after the edge, once the registered pulse has settled
  task automatic wait_conv(output int cnt);
    cnt = 0;
    do begin
      @(posedge clock_i);
      #1;
      cnt++;
    end while (convert_start_o !== 1'b1 && cnt < 40);
  endtask : wait_conv
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    #1_500_000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (int a = 0; a <= 9; a++) rd(addr_t'(a), 8'h00, "reset value");
    wr(`ADDR_IRQ_ENABLE, 8'h04);
    foreach (modes[i]) begin
      wr(`ADDR_CAPTURE_CONTROL, `RESET_BYTE);
      set_timer(16'h0F0F);
      wr(`ADDR_CAPTURE_CONTROL, {4'h0, modes[i]});
      wr(`ADDR_IRQ_CLEAR, 8'hFF);
      repeat (needs[i] - 1) pin_u.pulse();
      rd(`ADDR_IRQ_STATUS, 8'h00, "status before last edge");
      set_timer(16'hA5C0 + 16'(i));
      pin_u.pulse();
      rd(`ADDR_IRQ_STATUS, 8'h04, "status after capture");
      chk1("irq", 1'b1, irq_o);
      rd_hold(16'hA5C0 + 16'(i));
    end
    wr(`ADDR_CAPTURE_CONTROL, {4'h0, `MODE_RISE});
    set_timer(16'h1234);
    pin_u.pulse();
    rd_hold(16'h1234);
    rd(`ADDR_IRQ_STATUS, 8'h04, "status after overwrite");
    wr(`ADDR_IRQ_ENABLE, 8'h00);
    #1 chk1("irq masked", 1'b0, irq_o);
    wr(`ADDR_IRQ_CLEAR, 8'h04);
    rd(`ADDR_IRQ_STATUS, 8'h00, "status cleared");
    wr(`ADDR_IRQ_ENABLE, 8'h04);
    wr(`ADDR_CAPTURE_CONTROL, {4'h0, `MODE_RISE4});
    repeat (2) pin_u.pulse();
    wr(`ADDR_CAPTURE_CONTROL, {4'h0, `MODE_RISE16});
    wr(`ADDR_IRQ_CLEAR, 8'hFF);
    repeat (13) pin_u.pulse();
    rd(`ADDR_IRQ_STATUS, 8'h00, "status part count");
    set_timer(16'h0777);
    pin_u.pulse();
    rd(`ADDR_IRQ_STATUS, 8'h04, "status kept count");
    rd_hold(16'h0777);
    set_timer(16'h0778);
    wr(`ADDR_CAPTURE_CONTROL, {4'h0, `MODE_CMP_HIGH});
    wr(`ADDR_IRQ_CLEAR, 8'hFF);
    rd(`ADDR_IRQ_STATUS, 8'h00, "status no match");
    wr(`ADDR_TIMER_LOW, 8'h77);
    rd(`ADDR_IRQ_STATUS, 8'h04, "status on match");
    chk1("compare pin", 1'b1, compare_pin_o);
    chk1("pin enable", 1'b0, compare_pin_oe_n_o);
    wr(`ADDR_CAPTURE_CONTROL, `RESET_BYTE);
    @(posedge clock_i);
    #1 chk1("pin released", 1'b1, compare_pin_oe_n_o);
    wr(`ADDR_HOLD_LOW, 8'h10);
    wr(`ADDR_HOLD_HIGH, 8'h00);
    set_timer(`RESET_WORD);
    wr(`ADDR_IRQ_CLEAR, 8'hFF);
    wr(`ADDR_TIMER_CONTROL, 8'h03);
    wr(`ADDR_CAPTURE_CONTROL, {4'h0, `MODE_TRIGGER});
    wait_conv(n);
    chk1("convert start", 1'b1, convert_start_o);
    wait_conv(n);
    chk8("trigger period", 8'd17, byte_t'(n));
    rd(`ADDR_IRQ_STATUS, 8'h04, "status after trigger");
    wr(`ADDR_TIMER_CONTROL, 8'h02);
    wr(`ADDR_TIMER_HIGH, 8'h00);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= `ADDR_TIMER_LOW;
    wdata_i <= 8'h10;
    @(posedge clock_i);
    wdata_i <= 8'h33;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd(`ADDR_TIMER_LOW, 8'h33, "timer write beats trigger");
    wr(`ADDR_CAPTURE_CONTROL, `RESET_BYTE);
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    set_timer(`TIMER_MAX);
    wr(`ADDR_IRQ_CLEAR, 8'hFF);
    wr(`ADDR_TIMER_CONTROL, 8'h01);
    rd(`ADDR_IRQ_STATUS, 8'h01, "overflow by counting");
    tally_and_finish();
  end
endmodule : timer_capture_event_trigger_test
`default_nettype wire
